// file: asb_config_bank.sv
// Second time slot front-end configuration register bank
// Overview of operation
// - Five-bit window width in timing bits 15:11, 1 us units, reset 0x04.
// - Six-bit coarse window offset in timing bits 10:5, 1 us units, reset 0x17.
// - Five-bit fine window offset in timing bits 4:0, 31.25 ns steps, reset 0x1C.
// - Buffer bit or digital integrate mode turns integrator into a buffer.
// - Per-channel enable takes channel 1 locally, channels 2-4 from 0x55 bits 11:6.
// - Gain code 0..3 means 200k..25k ohm; one channel or all four.
// - Two-bit amplifier bias select, reset code 3.
// - Digital integration register bit 13 enables second-slot digital integration.
// - Digital integration register bit 12 enables first-slot digital integration.
`include "asb_regs.svh"
module asb_config_bank (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Register port from the serial control interface
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_hit,
	// Channel 2-4 gain word from register 0x55 bits 11:6
	input  wire logic [5:0]  ch234_gain_src,
	// Timing to the slot sequencer
	output logic [4:0]       second_slot_window_width,
	output logic [5:0]       second_slot_window_coarse_offset,
	output logic [4:0]       second_slot_window_fine_offset,
	// Front-end controls
	output logic [7:0]       second_slot_frontend_mode,
	output logic             second_slot_integrator_as_buffer,
	output logic             second_slot_per_channel_gain_enable,
	output logic [1:0]       second_slot_amp_bias_select,
	output logic [7:0]       second_slot_channel_gain,
	output logic [15:0]      second_slot_path_connection,
	output logic             second_slot_digital_integration_enable,
	output logic             first_slot_digital_integration_enable
);
	asb_pkg::asb_state_t s_q;
	asb_pkg::asb_state_t s_d;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == `ASB_ADDR_TIMING) || (a == `ASB_ADDR_MODE_GAIN) ||
			(a == `ASB_ADDR_PATH) || (a == `ASB_ADDR_DIG_INT);
	endfunction

	// Read multiplexer; unmapped offsets read as zero
	function automatic logic [15:0] read_word(input asb_pkg::asb_state_t s, input logic [7:0] a);
		unique case (a)
			`ASB_ADDR_TIMING:    read_word = s.timing;
			`ASB_ADDR_MODE_GAIN: read_word = s.mode_gain;
			`ASB_ADDR_PATH:      read_word = s.path;
			`ASB_ADDR_DIG_INT:   read_word = s.dig_int;
			default:             read_word = 16'h0000;
		endcase
	endfunction

	always_comb begin
		s_d = s_q;
		if (reg_wr) begin
			unique case (reg_addr)
				`ASB_ADDR_TIMING:    s_d.timing = reg_wdata;
				`ASB_ADDR_MODE_GAIN: s_d.mode_gain = reg_wdata;
				`ASB_ADDR_PATH:      s_d.path = reg_wdata;
				`ASB_ADDR_DIG_INT:   s_d.dig_int = reg_wdata;
				default:             s_d = s_q;
			endcase
		end
		if (reg_rd) begin
			s_d.rdata = read_word(s_q, reg_addr);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_q.timing    <= `ASB_RST_TIMING;
			s_q.mode_gain <= `ASB_RST_MODE_GAIN;
			s_q.path      <= `ASB_RST_PATH;
			s_q.dig_int   <= `ASB_RST_DIG_INT;
			s_q.rdata     <= 16'h0000;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign reg_hit   = addr_known(reg_addr);

	assign second_slot_window_width         = s_q.timing[`ASB_WIDTH_MSB:`ASB_WIDTH_LSB];
	assign second_slot_window_coarse_offset = s_q.timing[`ASB_COARSE_MSB:`ASB_COARSE_LSB];
	assign second_slot_window_fine_offset   = s_q.timing[`ASB_FINE_MSB:`ASB_FINE_LSB];
	assign second_slot_frontend_mode        = s_q.mode_gain[`ASB_MODE_MSB:`ASB_MODE_LSB];
	assign second_slot_integrator_as_buffer = s_q.mode_gain[`ASB_BUF_BIT] ||
		(second_slot_frontend_mode == `ASB_MODE_DIG_INT);
	assign second_slot_per_channel_gain_enable = s_q.mode_gain[`ASB_IND_BIT];
	assign second_slot_amp_bias_select      = s_q.mode_gain[`ASB_BIAS_MSB:`ASB_BIAS_LSB];
	// Channel 1 in bits 1:0, channel 4 in bits 7:6
	logic [1:0] shared_gain;
	assign shared_gain = s_q.mode_gain[`ASB_GAIN_MSB:`ASB_GAIN_LSB];
	for (genvar ch = 0; ch < 4; ch++) begin : g_chan_gain
		if (ch == 0) begin : g_local
			assign second_slot_channel_gain[1:0] = shared_gain;
		end else begin : g_remote
			assign second_slot_channel_gain[2*ch+1:2*ch] = second_slot_per_channel_gain_enable ?
				ch234_gain_src[2*ch-1:2*ch-2] : shared_gain;
		end
	end
	assign second_slot_path_connection = s_q.path;
	assign second_slot_digital_integration_enable = s_q.dig_int[`ASB_DIGB_BIT];
	assign first_slot_digital_integration_enable  = s_q.dig_int[`ASB_DIGA_BIT];

	a_width_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_TIMING |=> second_slot_window_width == $past(reg_wdata[15:11]))
		else $error("window width not loaded");
	a_coarse_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_TIMING |=> second_slot_window_coarse_offset == $past(reg_wdata[10:5]))
		else $error("coarse offset not loaded");
	a_fine_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_TIMING |=> second_slot_window_fine_offset == $past(reg_wdata[4:0]))
		else $error("fine offset not loaded");
	a_buf_forced: assert property (@(posedge clk) disable iff (!rst_b)
		second_slot_frontend_mode == 8'h1d || s_q.mode_gain[7] |-> second_slot_integrator_as_buffer)
		else $error("integrator not converted to buffer");
	a_gain_shared: assert property (@(posedge clk) disable iff (!rst_b)
		!second_slot_per_channel_gain_enable |-> second_slot_channel_gain[7:6] == s_q.mode_gain[1:0])
		else $error("shared gain not applied to channel 4");
	a_gain_indiv: assert property (@(posedge clk) disable iff (!rst_b)
		second_slot_per_channel_gain_enable |-> second_slot_channel_gain[7:2] == ch234_gain_src)
		else $error("individual gains not taken from source");
	a_bias_reset: assert property (@(posedge clk)
		!rst_b |=> second_slot_amp_bias_select == 2'h3 && second_slot_path_connection == 16'hada5)
		else $error("bias or path reset value wrong");
	a_digb_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_DIG_INT |=> second_slot_digital_integration_enable == $past(reg_wdata[13]))
		else $error("slot B digital enable not loaded");
	a_diga_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_DIG_INT |=> first_slot_digital_integration_enable == $past(reg_wdata[12]))
		else $error("slot A digital enable not loaded");
	a_path_read: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd && !reg_wr && reg_addr == `ASB_ADDR_PATH ##1 !reg_wr |-> reg_rdata == second_slot_path_connection)
		else $error("path read mismatch");

	// Field values after reset
	a_width_reset: assert property (@(posedge clk)
		!rst_b
		|=> second_slot_window_width == 5'h04)
		else $error("window width reset value wrong");
	a_coarse_reset: assert property (@(posedge clk)
		!rst_b
		|=> second_slot_window_coarse_offset == 6'h17)
		else $error("coarse offset reset value wrong");
	a_fine_reset: assert property (@(posedge clk)
		!rst_b
		|=> second_slot_window_fine_offset == 5'h1c)
		else $error("fine offset reset value wrong");
	a_mode_reset: assert property (@(posedge clk)
		!rst_b
		|=> second_slot_frontend_mode == 8'h1c)
		else $error("mode reset value wrong");
	a_buf_reset: assert property (@(posedge clk)
		!rst_b
		|=> !second_slot_integrator_as_buffer)
		else $error("buffer set after reset");
	a_indiv_reset: assert property (@(posedge clk)
		!rst_b
		|=> !second_slot_per_channel_gain_enable)
		else $error("individual gain set after reset");
	a_gain_reset: assert property (@(posedge clk)
		!rst_b
		|=> second_slot_channel_gain == 8'h00)
		else $error("gain reset value wrong");
	a_digb_reset: assert property (@(posedge clk)
		!rst_b
		|=> !second_slot_digital_integration_enable)
		else $error("second slot digital enable set after reset");
	a_diga_reset: assert property (@(posedge clk)
		!rst_b
		|=> !first_slot_digital_integration_enable)
		else $error("first slot digital enable set after reset");
	a_rdata_reset: assert property (@(posedge clk)
		!rst_b
		|=> reg_rdata == 16'h0000)
		else $error("read data not cleared by reset");
	a_modegain_reset: assert property (@(posedge clk)
		!rst_b
		|=> s_q.mode_gain == 16'h1c38)
		else $error("mode and gain word reset value wrong");

	// Writes to single fields and to whole register words
	a_mode_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN
		|=> second_slot_frontend_mode == $past(reg_wdata[15:8]))
		else $error("mode not loaded");
	a_bufbit_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN && reg_wdata[7]
		|=> second_slot_integrator_as_buffer)
		else $error("buffer bit not applied");
	a_buf_clear: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN && !reg_wdata[7] && reg_wdata[15:8] != 8'h1d
		|=> !second_slot_integrator_as_buffer)
		else $error("buffer set without cause");
	a_indiv_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN
		|=> second_slot_per_channel_gain_enable == $past(reg_wdata[6]))
		else $error("individual gain enable not loaded");
	a_bias_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN
		|=> second_slot_amp_bias_select == $past(reg_wdata[5:4]))
		else $error("bias select not loaded");
	a_gain_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN
		|=> second_slot_channel_gain[1:0] == $past(reg_wdata[1:0]))
		else $error("channel 1 gain not loaded");
	a_modegain_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN
		|=> s_q.mode_gain == $past(reg_wdata))
		else $error("mode and gain word not stored whole");
	a_timing_word: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_TIMING
		|=> s_q.timing == $past(reg_wdata))
		else $error("timing word not stored whole");
	a_path_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_PATH
		|=> second_slot_path_connection == $past(reg_wdata))
		else $error("path word not loaded");
	a_dig_word: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == `ASB_ADDR_DIG_INT
		|=> s_q.dig_int == $past(reg_wdata))
		else $error("digital integration word not stored whole");

	// Registers hold unless written; read data holds unless read
	a_timing_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!(reg_wr && reg_addr == `ASB_ADDR_TIMING)
		|=> $stable(s_q.timing))
		else $error("timing changed without write");
	a_mode_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!(reg_wr && reg_addr == `ASB_ADDR_MODE_GAIN)
		|=> $stable(s_q.mode_gain))
		else $error("mode and gain changed without write");
	a_path_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!(reg_wr && reg_addr == `ASB_ADDR_PATH)
		|=> $stable(s_q.path))
		else $error("path changed without write");
	a_dig_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!(reg_wr && reg_addr == `ASB_ADDR_DIG_INT)
		|=> $stable(s_q.dig_int))
		else $error("digital integration changed without write");
	a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!reg_rd
		|=> $stable(reg_rdata))
		else $error("read data changed without read");
	a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_b)
		reg_wr && !addr_known(reg_addr)
		|=> $stable(s_q.timing) && $stable(s_q.mode_gain) && $stable(s_q.path) && $stable(s_q.dig_int))
		else $error("unmapped write changed a register");

	// Read data
	a_timing_read: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd && reg_addr == `ASB_ADDR_TIMING
		|=> reg_rdata == $past(s_q.timing))
		else $error("timing read mismatch");
	a_mg_read: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd && reg_addr == `ASB_ADDR_MODE_GAIN
		|=> reg_rdata == $past(s_q.mode_gain))
		else $error("mode and gain read mismatch");
	a_path_readback: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd && reg_addr == `ASB_ADDR_PATH
		|=> reg_rdata == $past(s_q.path))
		else $error("path read returned wrong word");
	a_dig_read: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd && reg_addr == `ASB_ADDR_DIG_INT
		|=> reg_rdata == $past(s_q.dig_int))
		else $error("digital integration read mismatch");
	a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rd && !addr_known(reg_addr)
		|=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");

	// Gain routing and buffer selection
	a_gain_ch1_local: assert property (@(posedge clk) disable iff (!rst_b)
		second_slot_per_channel_gain_enable
		|-> second_slot_channel_gain[1:0] == s_q.mode_gain[1:0])
		else $error("channel 1 gain not local");
	a_gain_shared_mid: assert property (@(posedge clk) disable iff (!rst_b)
		!second_slot_per_channel_gain_enable
		|-> second_slot_channel_gain[5:2] == {2{s_q.mode_gain[1:0]}})
		else $error("shared gain not applied to channels 2 and 3");
	a_buf_off: assert property (@(posedge clk) disable iff (!rst_b)
		!s_q.mode_gain[7] && second_slot_frontend_mode != 8'h1d
		|-> !second_slot_integrator_as_buffer)
		else $error("integrator converted without cause");

	c_dig_mode: cover property (@(posedge clk) disable iff (!rst_b)
		second_slot_frontend_mode == 8'h1d && second_slot_digital_integration_enable);
	c_indiv_gain: cover property (@(posedge clk) disable iff (!rst_b) second_slot_per_channel_gain_enable);
	c_path_nobuf: cover property (@(posedge clk) disable iff (!rst_b) second_slot_path_connection == 16'hb065);
	c_buf_bit: cover property (@(posedge clk) disable iff (!rst_b)
		second_slot_integrator_as_buffer && second_slot_frontend_mode == 8'h1c);
	c_unmapped_read: cover property (@(posedge clk) disable iff (!rst_b)
		reg_rd && !reg_hit);
endmodule

// file: asb_pkg.sv
// Types of the second-slot config bank
package asb_pkg;
	typedef struct packed {
		logic [15:0] timing;
		logic [15:0] mode_gain;
		logic [15:0] path;
		logic [15:0] dig_int;
		logic [15:0] rdata;
	} asb_state_t;
endpackage

// file: asb_regs.svh
// Register offsets, field positions and reset values of the second-slot config bank
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH
`define ASB_ADDR_TIMING      8'h3b
`define ASB_ADDR_MODE_GAIN   8'h44
`define ASB_ADDR_PATH        8'h45
`define ASB_ADDR_DIG_INT     8'h58
`define ASB_ADDR_CH234_GAIN  8'h55
`define ASB_RST_TIMING       16'h22fc
`define ASB_RST_MODE_GAIN    16'h1c38
`define ASB_RST_PATH         16'hada5
`define ASB_RST_DIG_INT      16'h0000
`define ASB_MODE_FULL        8'h1c
`define ASB_MODE_DIG_INT     8'h1d
`define ASB_PATH_FULL        16'hada5
`define ASB_PATH_AMP_BUF     16'hae65
`define ASB_PATH_AMP_NOBUF   16'hb065
`define ASB_WIDTH_MSB        15
`define ASB_WIDTH_LSB        11
`define ASB_COARSE_MSB       10
`define ASB_COARSE_LSB       5
`define ASB_FINE_MSB         4
`define ASB_FINE_LSB         0
`define ASB_MODE_MSB         15
`define ASB_MODE_LSB         8
`define ASB_BUF_BIT          7
`define ASB_IND_BIT          6
`define ASB_BIAS_MSB         5
`define ASB_BIAS_LSB         4
`define ASB_GAIN_MSB         1
`define ASB_GAIN_LSB         0
`define ASB_DIGB_BIT         13
`define ASB_DIGA_BIT         12
`endif

// file: tb.sv
// Self-checking bench for the second-slot config bank
`include "asb_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus and observed outputs
	logic        clk, rst_b, reg_wr, reg_rd, reg_hit, as_buf, ind_en, dig_b, dig_a;
	logic [7:0]  reg_addr, mode, gain;
	logic [15:0] reg_wdata, reg_rdata, path;
	logic [5:0]  ch234_gain_src, coarse;
	logic [4:0]  width, fine;
	logic [1:0]  bias;
	int          error_cnt = 0, comparisons = 0, cyc = 0;
	asb_config_bank dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_hit(reg_hit), .ch234_gain_src(ch234_gain_src),
		.second_slot_window_width(width), .second_slot_window_coarse_offset(coarse),
		.second_slot_window_fine_offset(fine), .second_slot_frontend_mode(mode),
		.second_slot_integrator_as_buffer(as_buf),
		.second_slot_per_channel_gain_enable(ind_en), .second_slot_amp_bias_select(bias),
		.second_slot_channel_gain(gain), .second_slot_path_connection(path),
		.second_slot_digital_integration_enable(dig_b),
		.first_slot_digital_integration_enable(dig_a));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task summarize;
		$display("Counts: %0d mismatches, %0d comparisons", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			$display("Error %0t: timeout", $time);
			summarize();
		end
	end
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] exp, input logic hit);
		@(posedge clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
		cmp({15'h0, reg_hit}, {15'h0, hit});
	endtask
	task reset_and_check;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(`ASB_ADDR_TIMING, {5'h04, 6'h17, 5'h1c}, 1'b1);
		rd(`ASB_ADDR_MODE_GAIN, {8'h1c, 4'b0011, 4'b1000}, 1'b1);
		rd(`ASB_ADDR_PATH, 16'hada5, 1'b1);
		rd(`ASB_ADDR_DIG_INT, 16'h0000, 1'b1);
		cmp({14'h0, bias}, 16'h3);
		$display("test reset done");
	endtask
	initial begin
		rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
		reg_addr = 8'h00; reg_wdata = 16'h0000; ch234_gain_src = 6'h39;
		reset_and_check();
		wr(`ASB_ADDR_TIMING, {5'h1f, 6'h2a, 5'h15});
		cmp({width, coarse, fine}, {5'h1f, 6'h2a, 5'h15});
		$display("test timing done");
		for (int i = 0; i < 4; i++) begin
			wr(`ASB_ADDR_MODE_GAIN, {7'h0e, i[1], i[0], 7'h20});
			cmp({mode, 7'h0, as_buf}, {7'h0e, i[1], 7'h0, i[0] | i[1]});
		end
		$display("test mode done");
		for (int g = 0; g < 4; g++) begin
			wr(`ASB_ADDR_MODE_GAIN, {8'h1c, 4'b0001, 2'b01, g[1:0]});
			cmp({8'h0, gain}, {8'h0, {4{g[1:0]}}});
			wr(`ASB_ADDR_MODE_GAIN, {8'h1c, 4'b0101, 2'b01, g[1:0]});
			cmp({7'h0, ind_en, gain}, {7'h0, 1'b1, 6'h39, g[1:0]});
		end
		$display("test gain done");
		wr(`ASB_ADDR_PATH, 16'hae65);
		cmp(path, 16'hae65);
		wr(`ASB_ADDR_PATH, 16'hb065);
		rd(`ASB_ADDR_PATH, 16'hb065, 1'b1);
		wr(`ASB_ADDR_DIG_INT, 16'h2000);
		cmp({14'h0, dig_b, dig_a}, 16'h2);
		wr(`ASB_ADDR_DIG_INT, 16'h1000);
		cmp({14'h0, dig_b, dig_a}, 16'h1);
		wr(`ASB_ADDR_DIG_INT, 16'hffff);
		wr(8'h55, 16'h5555);
		rd(8'h55, 16'h0000, 1'b0);
		rd(`ASB_ADDR_DIG_INT, 16'hffff, 1'b1);
		$display("test access done");
		reset_and_check();
		summarize();
	end
endmodule
